// ==== logic/isr_cfg.svh ====
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// register addresses on the serial register port
`define ISR_ADDR_INTSEL   8'h0a
`define ISR_ADDR_STATUS   8'h20
`define ISR_ADDR_RP_LO    8'h21
`define ISR_ADDR_RP_HI    8'h22
`define ISR_ADDR_L_LO     8'h23
`define ISR_ADDR_L_HI     8'h24

// status bit positions
`define ISR_ST_OSC_LOST   7
`define ISR_ST_READY_N    6
`define ISR_ST_RP_HIGH_N  5
`define ISR_ST_RP_HYST    4
`define ISR_ST_L_HIGH_N   3
`define ISR_ST_L_HYST     2
`define ISR_ST_RSVD       1
`define ISR_ST_POR        0

// interrupt function select codes and the clearing write value
`define ISR_FUNC_RP_HIGH  6'h01
`define ISR_FUNC_L_HIGH   6'h08
`define ISR_CLEAR_VALUE   8'h00

// reset values
`define ISR_RST_FUNC      6'h00
`define ISR_RST_RESULT    16'h0000
`define ISR_RST_FLAG      1'b0
`define ISR_RST_BYTE      8'h00

`endif

// ==== logic/isr_pkg.sv ====
package isr_pkg;

  // whole state of the status and result bank
  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        por_s1;
    logic        por_s2;
    logic [5:0]  func;
    logic [15:0] rp;
    logic [15:0] l;
    logic [7:0]  snap_rp_hi;
    logic [15:0] snap_l;
    logic        ready_n;
    logic        rp_high_n;
    logic        rp_hyst;
    logic        l_high_n;
    logic        l_hyst;
    logic [7:0]  rdata;
  } isr_state_t;

endpackage : isr_pkg

// ==== logic/isr_cmp_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// one threshold comparison: result against upper and lower thresholds
interface isr_cmp_if #(
  parameter int W = 16
);
  logic [W-1:0] value;
  logic [W-1:0] upper;
  logic [W-1:0] lower;
  logic         above_upper;
  logic         below_lower;

  modport cmp (
    input  value,
    input  upper,
    input  lower,
    output above_upper,
    output below_lower
  );
  modport user (
    output value,
    output upper,
    output lower,
    input  above_upper,
    input  below_lower
  );
endinterface : isr_cmp_if

`default_nettype wire

// ==== logic/isr_cmp.sv ====
`timescale 1ns/1ps
`default_nettype none

module isr_cmp (
  isr_cmp_if.cmp c
);
  // strict compares, so a result equal to a threshold moves nothing
  assign c.above_upper = c.value > c.upper;
  assign c.below_lower = c.value < c.lower;
endmodule : isr_cmp

`default_nettype wire

// ==== logic/isr_status_results.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isr_cfg.svh"

module isr_status_results #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         osc_lost,
  input  wire logic         por_busy,
  input  wire logic         conv_valid,
  input  wire logic [W-1:0] rp_result,
  input  wire logic [W-1:0] l_result,
  input  wire logic [W-1:0] rp_upper,
  input  wire logic [W-1:0] rp_lower,
  input  wire logic [W-1:0] l_upper,
  input  wire logic [W-1:0] l_lower,
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_rd,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_wdata,
  output var  logic [7:0]   reg_rdata,
  output var  logic [5:0]   int_func_sel
);

  isr_pkg::isr_state_t st_q;
  isr_pkg::isr_state_t st_d;

  isr_cmp_if #(.W(W)) rp_c ();
  isr_cmp_if #(.W(W)) l_c ();

  // both comparators look at the fresh conversion, not the stored one
  assign rp_c.value = rp_result;
  assign rp_c.upper = rp_upper;
  assign rp_c.lower = rp_lower;
  assign l_c.value  = l_result;
  assign l_c.upper  = l_upper;
  assign l_c.lower  = l_lower;

  isr_cmp u_rp_cmp (
    .c (rp_c.cmp)
  );
  isr_cmp u_l_cmp (
    .c (l_c.cmp)
  );

  logic       cfg_ok;
  logic       clr_wr;
  logic       rd_snap;
  logic       rp_hit;
  logic       l_hit;
  logic [7:0] status;

  // config writes only count once the reset flag has dropped
  assign cfg_ok  = !st_q.por_s2;
  assign clr_wr  = reg_wr && cfg_ok && reg_addr == `ISR_ADDR_INTSEL
                   && reg_wdata == `ISR_CLEAR_VALUE;
  assign rd_snap = reg_rd && reg_addr == `ISR_ADDR_RP_LO;
  assign rp_hit  = conv_valid && rp_c.above_upper
                   && st_q.func == `ISR_FUNC_RP_HIGH;
  assign l_hit   = conv_valid && l_c.above_upper
                   && st_q.func == `ISR_FUNC_L_HIGH;

  // status byte as the host sees it
  always_comb begin
    status                    = 8'h00;
    status[`ISR_ST_OSC_LOST]  = st_q.osc_s2;
    status[`ISR_ST_READY_N]   = st_q.ready_n;
    status[`ISR_ST_RP_HIGH_N] = st_q.rp_high_n;
    status[`ISR_ST_RP_HYST]   = st_q.rp_hyst;
    status[`ISR_ST_L_HIGH_N]  = st_q.l_high_n;
    status[`ISR_ST_L_HYST]    = st_q.l_hyst;
    status[`ISR_ST_RSVD]      = 1'b0;
    status[`ISR_ST_POR]       = st_q.por_s2;
  end

  // next state of the whole bank
  always_comb begin
    st_d        = st_q;
    st_d.osc_s1 = osc_lost;
    st_d.osc_s2 = st_q.osc_s1;
    st_d.por_s1 = por_busy;
    st_d.por_s2 = st_q.por_s1;
    if (reg_wr && cfg_ok && reg_addr == `ISR_ADDR_INTSEL) begin
      st_d.func = reg_wdata[5:0];
    end
    // clearing write first, so a crossing in the same cycle wins
    if (clr_wr) begin
      st_d.rp_high_n = 1'b1;
      st_d.l_high_n  = 1'b1;
    end
    if (rp_hit) begin
      st_d.rp_high_n = 1'b0;
    end
    if (l_hit) begin
      st_d.l_high_n = 1'b0;
    end
    // reading the low byte consumes the result; a new one wins
    if (rd_snap) begin
      st_d.ready_n    = 1'b1;
      st_d.snap_rp_hi = st_q.rp[15:8];
      st_d.snap_l     = st_q.l;
    end
    if (conv_valid) begin
      st_d.rp      = rp_result[15:0];
      st_d.l       = l_result[15:0];
      st_d.ready_n = 1'b0;
      // between thresholds the hysteresis bits hold
      if (rp_c.above_upper) begin
        st_d.rp_hyst = 1'b0;
      end else if (rp_c.below_lower) begin
        st_d.rp_hyst = 1'b1;
      end
      if (l_c.above_upper) begin
        st_d.l_hyst = 1'b0;
      end else if (l_c.below_lower) begin
        st_d.l_hyst = 1'b1;
      end
    end
    // read data: the resistance high byte and both inductance bytes come from the snapshot
    st_d.rdata = `ISR_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `ISR_ADDR_INTSEL: st_d.rdata = {2'b00, st_q.func};
        `ISR_ADDR_STATUS: st_d.rdata = status;
        `ISR_ADDR_RP_LO:  st_d.rdata = st_q.rp[7:0];
        `ISR_ADDR_RP_HI:  st_d.rdata = st_q.snap_rp_hi;
        `ISR_ADDR_L_LO:   st_d.rdata = st_q.snap_l[7:0];
        `ISR_ADDR_L_HI:   st_d.rdata = st_q.snap_l[15:8];
        default:          st_d.rdata = `ISR_RST_BYTE;
      endcase
    end
  end

  // one register for everything
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q            <= '0;
      st_q.func       <= `ISR_RST_FUNC;
      st_q.rp         <= `ISR_RST_RESULT;
      st_q.l          <= `ISR_RST_RESULT;
      st_q.ready_n    <= `ISR_RST_FLAG;
      st_q.rp_high_n  <= `ISR_RST_FLAG;
      st_q.l_high_n   <= `ISR_RST_FLAG;
      st_q.rdata      <= `ISR_RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata    = st_q.rdata;
  assign int_func_sel = st_q.func;

  a_osc_report: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `ISR_ADDR_STATUS
    |=> reg_rdata[`ISR_ST_OSC_LOST] == $past(st_q.osc_s2))
    else $error("oscillation flag misreported");

  a_ready_new: assert property (
    @(posedge ref_clk) disable iff (rst)
    conv_valid |=> !st_q.ready_n)
    else $error("ready flag not low after a conversion");

  a_ready_used: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_snap && !conv_valid |=> st_q.ready_n)
    else $error("ready flag not raised after low byte read");

  a_rp_latch: assert property (
    @(posedge ref_clk) disable iff (rst)
    conv_valid && rp_result > rp_upper
    && st_q.func == `ISR_FUNC_RP_HIGH |=> !st_q.rp_high_n)
    else $error("resistance high flag not latched");

  a_rp_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !st_q.rp_high_n && !clr_wr |=> !st_q.rp_high_n)
    else $error("resistance high flag released without clear");

  a_rp_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_q.rp_high_n && st_q.func != `ISR_FUNC_RP_HIGH
    |=> st_q.rp_high_n)
    else $error("resistance high flag set while not selected");

  a_rp_hyst: assert property (
    @(posedge ref_clk) disable iff (rst)
    conv_valid && rp_result < rp_lower && !(rp_result > rp_upper)
    |=> st_q.rp_hyst)
    else $error("resistance hysteresis not set below lower");

  a_l_latch: assert property (
    @(posedge ref_clk) disable iff (rst)
    conv_valid && l_result == l_upper && st_q.l_high_n
    |=> st_q.l_high_n)
    else $error("inductance flag set on an equal result");

  a_l_hyst: assert property (
    @(posedge ref_clk) disable iff (rst)
    conv_valid && l_result > l_upper |=> !st_q.l_hyst)
    else $error("inductance hysteresis not cleared above upper");

  a_rsvd_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `ISR_ADDR_STATUS
    |=> reg_rdata[`ISR_ST_RSVD] == 1'b0)
    else $error("reserved status bit not zero");

  a_por_ignore: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_q.por_s2 |=> $stable(st_q.func))
    else $error("configuration changed during reset");

  a_snap_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_snap ##1 (reg_rd && reg_addr == `ISR_ADDR_L_HI)
    |=> reg_rdata == $past(st_q.l[15:8], 2))
    else $error("inductance high byte not from snapshot");

endmodule : isr_status_results

`default_nettype wire

// ==== verif/isr_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module isr_host (
  input  wire logic       ref_clk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_rd,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // bus idle at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // idle lines show the inverse so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // data stands one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  // two reads on consecutive edges, as a host may burst them
  task automatic rd_pair(input logic [7:0] a0, input logic [7:0] a1,
                         output logic [7:0] d0, output logic [7:0] d1);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a0;
    @(posedge ref_clk);
    reg_addr <= a1;
    #1;
    d0 = reg_rdata;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a1;
    #1;
    d1 = reg_rdata;
  endtask : rd_pair

  // sensor frequency as the host derives it; lval must not be zero
  function automatic logic [31:0] sensor_freq(input logic [31:0] fref,
                                              input logic [31:0] resp,
                                              input logic [15:0] lval);
    sensor_freq = (fref * resp) / (32'd3 * {16'h0000, lval});
  endfunction : sensor_freq

  // no configuration until the reset flag reads clear
  task automatic wait_por(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(8'h20, s);
      ok = (s[0] === 1'b0);
    end
  endtask : wait_por

  // low resistance byte first, so the other three come from one set
  task automatic rd_all(output logic [15:0] rp, output logic [15:0] l);
    rd(8'h21, rp[7:0]);
    rd(8'h22, rp[15:8]);
    rd(8'h23, l[7:0]);
    rd(8'h24, l[15:8]);
  endtask : rd_all
endmodule : isr_host

`default_nettype wire

// ==== verif/isr_status_results_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module isr_status_results_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        osc_lost = 1'b0;
  logic        por_busy = 1'b1;
  logic        conv_valid = 1'b0;
  logic [15:0] rp_result = 16'h0000;
  logic [15:0] l_result = 16'h0000;
  logic [15:0] rp_upper = 16'h1000;
  logic [15:0] rp_lower = 16'h0800;
  logic [15:0] l_upper = 16'h6000;
  logic [15:0] l_lower = 16'h2000;
  logic [7:0]  reg_addr;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [5:0]  int_func_sel;
  logic [15:0] rp;
  logic [15:0] l;
  logic        ok;
  logic [31:0] freq;
  logic [7:0]  b_lo;
  logic [7:0]  b_hi;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 ref_clk = ~ref_clk;

  isr_status_results i_dut (.ref_clk, .rst, .osc_lost, .por_busy,
    .conv_valid, .rp_result, .l_result, .rp_upper, .rp_lower, .l_upper,
    .l_lower, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .int_func_sel);
  isr_host i_host (.ref_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata);

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rchk

  // one-cycle conversion pulse; stale values inverted afterwards
  task automatic conv(logic [15:0] r, logic [15:0] n);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    rp_result  <= r;
    l_result   <= n;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    rp_result  <= ~r;
    l_result   <= ~n;
  endtask : conv

  // hang guard: the sequence needs about a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  // reset values, writes refused while the reset flag stands, release
  task automatic t_reset;
    repeat (3) @(posedge ref_clk);
    rchk("status", 8'h20, 8'h01);
    i_host.wr(8'h0a, 8'h01);
    rchk("func", 8'h0a, 8'h00);
    @(posedge ref_clk);
    por_busy <= 1'b0;
    i_host.wait_por(ok);
    chk("por_wait", 16'h0001, {15'h0000, ok});
    i_host.rd_all(rp, l);
    chk("rp", 16'h0000, rp);
    chk("l", 16'h0000, l);
    // latched flags reset low, so the clear shows them high
    i_host.wr(8'h0a, 8'h00);
    rchk("status", 8'h20, 8'h68);
    $display("done reset");
  endtask : t_reset

  // results, resistance latch, snapshot of the other bytes
  task automatic t_results;
    i_host.wr(8'h0a, 8'h01);
    rchk("func", 8'h0a, 8'h01);
    chk("func_sel", 16'h0001, {10'h000, int_func_sel});
    conv(16'h1234, 16'h5678);
    rchk("status", 8'h20, 8'h08);
    // a non-zero write to the select register must not clear the latch
    i_host.wr(8'h0a, 8'h01);
    conv(16'h1234, 16'h5678);
    rchk("status", 8'h20, 8'h08);
    rchk("rp_lo", 8'h21, 8'h34);
    conv(16'habcd, 16'h9876);
    rchk("rp_hi", 8'h22, 8'h12);
    rchk("l_lo", 8'h23, 8'h78);
    rchk("l_hi", 8'h24, 8'h56);
    i_host.rd_all(rp, l);
    chk("rp", 16'habcd, rp);
    chk("l", 16'h9876, l);
    rchk("status", 8'h20, 8'h48);
    // 117090 * 64 / (3 * 0x9876) gives 64
    freq = i_host.sensor_freq(32'd117090, 32'd64, l);
    chk("freq", 16'h0040, freq[15:0]);
    $display("done results");
  endtask : t_results

  // back to back low byte and inductance high byte reads
  task automatic t_snap;
    conv(16'h2468, 16'h3579);
    i_host.rd_pair(8'h21, 8'h24, b_lo, b_hi);
    chk("pair_lo", 16'h0068, {8'h00, b_lo});
    chk("pair_hi", 16'h0035, {8'h00, b_hi});
    $display("done snapshot");
  endtask : t_snap

  // inductance latch, strict compare, hysteresis, clear
  task automatic t_flags;
    i_host.wr(8'h0a, 8'h08);
    conv(16'h0400, 16'h6000);
    rchk("status", 8'h20, 8'h18);
    conv(16'h0400, 16'h6001);
    rchk("status", 8'h20, 8'h10);
    conv(16'h0400, 16'h1000);
    rchk("status", 8'h20, 8'h14);
    i_host.wr(8'h0a, 8'h00);
    rchk("status", 8'h20, 8'h3c);
    $display("done flags");
  endtask : t_flags

  // oscillation loss reaches the status byte through the synchroniser
  task automatic t_osc;
    @(posedge ref_clk);
    osc_lost <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk("status", 8'h20, 8'hbc);
    $display("done oscillation");
  endtask : t_osc

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_results();
    t_snap();
    t_flags();
    t_osc();
    end_of_test();
  end
endmodule : isr_status_results_test

`default_nettype wire
